// file: pkg/ldr_pkg.sv
// Shared constants for the low power DAC switch and reference register bank
package ldr_pkg;

   localparam int ADDR_W = 16;
   localparam int DATA_W = 32;

   // Byte addresses of the bank's registers
   localparam logic [15:0] REF_CTRL_OFF = 16'h2050;
   localparam logic [15:0] DATA_OFF     = 16'h2120;
   localparam logic [15:0] SWITCH_OFF   = 16'h2124;
   localparam logic [15:0] CONFIG_OFF   = 16'h2128;
   localparam logic [15:0] CMODE_OFF    = 16'h235C;

   // Switch register fields
   localparam int SW_ZERO_HSTIA  = 0;
   localparam int SW_ZERO_FILTER = 1;
   localparam int SW_ZERO_LPTIA  = 2;
   localparam int SW_BIAS_FILTER = 3;
   localparam int SW_BIAS_PSTAT  = 4;
   localparam int SW_OVERRIDE    = 5;
   localparam int SW_W           = 6;

   // Data register fields
   localparam int CODE12_LSB = 0;
   localparam int CODE12_W   = 12;
   localparam int CODE6_LSB  = 12;
   localparam int CODE6_W    = 6;

   // Reference control and common-mode fields
   localparam int REF_BANDGAP_PD = 0;
   localparam int REF_BUFFER_PD  = 1;
   localparam int REF_W          = 2;
   localparam int CM_SELECT      = 3;

   // Configuration register fields
   localparam int CFG_WR_EN  = 0;
   localparam int CFG_PWD    = 1;
   localparam int CFG_REFSEL = 2;
   localparam int CFG_VBMUX  = 3;
   localparam int CFG_VZMUX  = 4;
   localparam int CFG_DIAG   = 5;
   localparam int CFG_WAVE   = 6;
   localparam int CFG_W      = 7;

   // Reset values
   localparam logic [CFG_W-1:0]    CFG_RESET    = 7'h02;
   localparam logic [SW_W-1:0]     SWITCH_RESET = 6'h00;
   localparam logic [REF_W-1:0]    REF_RESET    = 2'h0;
   localparam logic [CODE6_W-1:0]  CODE6_RESET  = 6'h00;
   localparam logic [CODE12_W-1:0] CODE12_RESET = 12'h000;
   localparam logic                CM_RESET     = 1'b0;

   // Switch arrangements chosen by the diagnostic mode bit
   localparam logic [4:0] SW_NORMAL = 5'h0A;
   localparam logic [4:0] SW_DIAG   = 5'h14;

   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage

// file: pkg/ldr_reg_if.sv
// Register access carrier between the bus slave and the register bank
`timescale 1ns/1ns
`default_nettype none
interface ldr_reg_if;
   import ldr_pkg::*;
   logic              wr_req;
   logic [ADDR_W-1:0] wr_addr;
   logic [DATA_W-1:0] wr_data;
   logic [3:0]        wr_strb;
   logic              wr_hit;
   logic              rd_req;
   logic [ADDR_W-1:0] rd_addr;
   logic [DATA_W-1:0] rd_data;
   logic              rd_hit;

   modport slave (output wr_req, wr_addr, wr_data, wr_strb, rd_req, rd_addr,
                  input wr_hit, rd_data, rd_hit);
   modport bank  (input wr_req, wr_addr, wr_data, wr_strb, rd_req, rd_addr,
                  output wr_hit, rd_data, rd_hit);
endinterface
`default_nettype wire

// file: src/ldr_axil_slave.sv
// AXI4-Lite slave front end for the register bank
`timescale 1ns/1ns
`default_nettype none
module ldr_axil_slave
   import ldr_pkg::*;
(
   input  wire logic              aclk,
   input  wire logic              aresetn,
   input  wire logic [ADDR_W-1:0] awaddr,
   input  wire logic              awvalid,
   output logic                   awready,
   input  wire logic [DATA_W-1:0] wdata,
   input  wire logic [3:0]        wstrb,
   input  wire logic              wvalid,
   output logic                   wready,
   output logic [1:0]             bresp,
   output logic                   bvalid,
   input  wire logic              bready,
   input  wire logic [ADDR_W-1:0] araddr,
   input  wire logic              arvalid,
   output logic                   arready,
   output logic [DATA_W-1:0]      rdata,
   output logic [1:0]             rresp,
   output logic                   rvalid,
   input  wire logic              rready,
   ldr_reg_if.slave               rif
);

   typedef struct packed {
      logic              aw_held;
      logic [ADDR_W-1:0] aw_addr;
      logic              w_held;
      logic [DATA_W-1:0] w_data;
      logic [3:0]        w_strb;
      logic              bvalid;
      logic [1:0]        bresp;
      logic              rvalid;
      logic [DATA_W-1:0] rdata;
      logic [1:0]        rresp;
   } ldr_axil_t;

   ldr_axil_t s;
   ldr_axil_t next_s;
   logic      wr_go;
   logic      rd_go;

   // Address and data are parked separately so either may arrive first
   assign awready = !s.aw_held && !s.bvalid;
   assign wready  = !s.w_held && !s.bvalid;
   assign arready = !s.rvalid;
   assign wr_go   = s.aw_held && s.w_held && !s.bvalid;
   assign rd_go   = arvalid && arready;

   assign rif.wr_req  = wr_go;
   assign rif.wr_addr = s.aw_addr;
   assign rif.wr_data = s.w_data;
   assign rif.wr_strb = s.w_strb;
   assign rif.rd_req  = rd_go;
   assign rif.rd_addr = araddr;

   always_comb begin
      next_s = s;
      if (awvalid && awready) begin
         next_s.aw_held = 1'b1;
         next_s.aw_addr = awaddr;
      end
      if (wvalid && wready) begin
         next_s.w_held = 1'b1;
         next_s.w_data = wdata;
         next_s.w_strb = wstrb;
      end
      if (wr_go) begin
         next_s.aw_held = 1'b0;
         next_s.w_held  = 1'b0;
         next_s.bvalid  = 1'b1;
         next_s.bresp   = rif.wr_hit ? RESP_OKAY : RESP_SLVERR;
      end
      if (s.bvalid && bready) begin
         next_s.bvalid = 1'b0;
      end
      if (s.rvalid && rready) begin
         next_s.rvalid = 1'b0;
      end
      if (rd_go) begin
         next_s.rvalid = 1'b1;
         next_s.rdata  = rif.rd_hit ? rif.rd_data : '0;
         next_s.rresp  = rif.rd_hit ? RESP_OKAY : RESP_SLVERR;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s <= '0;
      end else begin
         s <= next_s;
      end
   end

   assign bvalid = s.bvalid;
   assign bresp  = s.bresp;
   assign rvalid = s.rvalid;
   assign rdata  = s.rdata;
   assign rresp  = s.rresp;

endmodule // ldr_axil_slave
`default_nettype wire

// file: src/ldr_regs.sv
// Low power DAC switch, code and reference register bank with its control outputs
//
// What this block does
// - Override clear, power-down clear: switches follow diagnostic mode bit.
// - Override set, power-down clear: switches follow five switch bits.
// - Bit 4 closes bias-to-potentiostat input path.
// - Bit 3 connects bias output to filter.
// - Bit 2 closes zero output to LPTIA.
// - Bit 1 connects zero output to filter.
// - Bit 0 connects zero output to HSTIA.
// - Data bits 17:12 hold six-bit code.
// - Data bits 11:0 hold twelve-bit code.
// - Reference bit 1 set powers buffer down.
// - Reference bit 0 set powers bandgap down.
// - Common-mode bit 3 clear leaves switches off.
// - Common-mode bit set closes both input switches.
// - Write enable clear: data writes ignored, reads zero.
// - Diagnostic bit selects diagnostic or normal arrangement.
`timescale 1ns/1ns
`default_nettype none
module ldr_regs
   import ldr_pkg::*;
(
   input  wire logic              aclk,
   input  wire logic              aresetn,
   input  wire logic [ADDR_W-1:0] awaddr,
   input  wire logic              awvalid,
   output logic                   awready,
   input  wire logic [DATA_W-1:0] wdata,
   input  wire logic [3:0]        wstrb,
   input  wire logic              wvalid,
   output logic                   wready,
   output logic [1:0]             bresp,
   output logic                   bvalid,
   input  wire logic              bready,
   input  wire logic [ADDR_W-1:0] araddr,
   input  wire logic              arvalid,
   output logic                   arready,
   output logic [DATA_W-1:0]      rdata,
   output logic [1:0]             rresp,
   output logic                   rvalid,
   input  wire logic              rready,
   output logic                   bias_to_pstat_input_switch,
   output logic                   bias_to_filter_pin_switch,
   output logic                   zero_to_lptia_input_switch,
   output logic                   zero_to_filter_pin_switch,
   output logic                   zero_to_hstia_input_switch,
   output logic [CODE6_W-1:0]     six_bit_code,
   output logic [CODE12_W-1:0]    twelve_bit_code,
   output logic                   ref_buffer_powerdown,
   output logic                   bandgap_powerdown,
   output logic                   cm_switch_analog_input_a,
   output logic                   cm_switch_analog_input_b,
   output logic                   dac_powerdown,
   output logic                   dac_ref_avdd_select,
   output logic                   bias_output_six_bit_select,
   output logic                   zero_output_twelve_bit_select,
   output logic                   waveform_source_select
);

   typedef struct packed {
      logic [CFG_W-1:0]    cfg;
      logic [SW_W-1:0]     sw;
      logic [CODE6_W-1:0]  code6;
      logic [CODE12_W-1:0] code12;
      logic [REF_W-1:0]    ref_ctrl;
      logic                cm;
      logic [4:0]          sw_out;
   } ldr_bank_t;

   ldr_bank_t   s;
   ldr_bank_t   next_s;
   logic [31:0] cur_word;
   logic [31:0] new_word;
   logic [31:0] strb_mask;

   ldr_reg_if rif ();

   ldr_axil_slave u_slave (
      .aclk    (aclk),
      .aresetn (aresetn),
      .awaddr  (awaddr),
      .awvalid (awvalid),
      .awready (awready),
      .wdata   (wdata),
      .wstrb   (wstrb),
      .wvalid  (wvalid),
      .wready  (wready),
      .bresp   (bresp),
      .bvalid  (bvalid),
      .bready  (bready),
      .araddr  (araddr),
      .arvalid (arvalid),
      .arready (arready),
      .rdata   (rdata),
      .rresp   (rresp),
      .rvalid  (rvalid),
      .rready  (rready),
      .rif     (rif)
   );

   function automatic logic hit(input logic [ADDR_W-1:0] a);
      logic [ADDR_W-3:0] w;
      w   = a[ADDR_W-1:2];
      hit = (w == REF_CTRL_OFF[ADDR_W-1:2]) || (w == DATA_OFF[ADDR_W-1:2]) ||
            (w == SWITCH_OFF[ADDR_W-1:2]) || (w == CONFIG_OFF[ADDR_W-1:2]) ||
            (w == CMODE_OFF[ADDR_W-1:2]);
   endfunction

   // Only defined fields are placed; everything above reads as zero
   function automatic logic [31:0] reg_word(input logic [ADDR_W-1:0] a,
                                            input ldr_bank_t b);
      logic [ADDR_W-3:0] w;
      w        = a[ADDR_W-1:2];
      reg_word = '0;
      if (w == REF_CTRL_OFF[ADDR_W-1:2]) begin
         reg_word[REF_W-1:0] = b.ref_ctrl;
      end else if (w == DATA_OFF[ADDR_W-1:2]) begin
         if (b.cfg[CFG_WR_EN]) begin
            reg_word[CODE6_LSB +: CODE6_W]   = b.code6;
            reg_word[CODE12_LSB +: CODE12_W] = b.code12;
         end
      end else if (w == SWITCH_OFF[ADDR_W-1:2]) begin
         reg_word[SW_W-1:0] = b.sw;
      end else if (w == CONFIG_OFF[ADDR_W-1:2]) begin
         reg_word[CFG_W-1:0] = b.cfg;
      end else if (w == CMODE_OFF[ADDR_W-1:2]) begin
         reg_word[CM_SELECT] = b.cm;
      end
   endfunction

   assign rif.rd_hit  = hit(rif.rd_addr);
   assign rif.rd_data = reg_word(rif.rd_addr, s);
   assign rif.wr_hit  = hit(rif.wr_addr);

   // Byte enables merge the write into the current word
   assign strb_mask = {{8{rif.wr_strb[3]}}, {8{rif.wr_strb[2]}},
                       {8{rif.wr_strb[1]}}, {8{rif.wr_strb[0]}}};
   assign cur_word  = reg_word(rif.wr_addr, s);
   assign new_word  = (cur_word & ~strb_mask) | (rif.wr_data & strb_mask);

   always_comb begin
      next_s = s;
      if (rif.wr_req) begin
         if (rif.wr_addr[ADDR_W-1:2] == REF_CTRL_OFF[ADDR_W-1:2]) begin
            next_s.ref_ctrl = new_word[REF_W-1:0];
         end
         if (rif.wr_addr[ADDR_W-1:2] == DATA_OFF[ADDR_W-1:2] && s.cfg[CFG_WR_EN]) begin
            next_s.code6  = new_word[CODE6_LSB +: CODE6_W];
            next_s.code12 = new_word[CODE12_LSB +: CODE12_W];
         end
         if (rif.wr_addr[ADDR_W-1:2] == SWITCH_OFF[ADDR_W-1:2]) begin
            next_s.sw = new_word[SW_W-1:0];
         end
         if (rif.wr_addr[ADDR_W-1:2] == CONFIG_OFF[ADDR_W-1:2]) begin
            next_s.cfg = new_word[CFG_W-1:0];
         end
         if (rif.wr_addr[ADDR_W-1:2] == CMODE_OFF[ADDR_W-1:2]) begin
            next_s.cm = new_word[CM_SELECT];
         end
      end
      // A disabled data register holds zero, so the DAC never sees stale codes
      if (!next_s.cfg[CFG_WR_EN]) begin
         next_s.code6  = CODE6_RESET;
         next_s.code12 = CODE12_RESET;
      end
      // Power-down opens all five routing switches regardless of routing mode; the common-mode switches keep following their bit
      if (s.cfg[CFG_PWD]) begin
         next_s.sw_out = '0;
      end else if (s.sw[SW_OVERRIDE]) begin
         next_s.sw_out = s.sw[4:0];
      end else begin
         next_s.sw_out = s.cfg[CFG_DIAG] ? SW_DIAG : SW_NORMAL;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s.cfg      <= CFG_RESET;
         s.sw       <= SWITCH_RESET;
         s.code6    <= CODE6_RESET;
         s.code12   <= CODE12_RESET;
         s.ref_ctrl <= REF_RESET;
         s.cm       <= CM_RESET;
         s.sw_out   <= '0;
      end else begin
         s <= next_s;
      end
   end

   assign bias_to_pstat_input_switch = s.sw_out[SW_BIAS_PSTAT];
   assign bias_to_filter_pin_switch  = s.sw_out[SW_BIAS_FILTER];
   assign zero_to_lptia_input_switch = s.sw_out[SW_ZERO_LPTIA];
   assign zero_to_filter_pin_switch  = s.sw_out[SW_ZERO_FILTER];
   assign zero_to_hstia_input_switch = s.sw_out[SW_ZERO_HSTIA];
   assign six_bit_code               = s.code6;
   assign twelve_bit_code            = s.code12;
   assign ref_buffer_powerdown       = s.ref_ctrl[REF_BUFFER_PD];
   assign bandgap_powerdown          = s.ref_ctrl[REF_BANDGAP_PD];
   assign cm_switch_analog_input_a   = s.cm;
   assign cm_switch_analog_input_b   = s.cm;
   assign dac_powerdown              = s.cfg[CFG_PWD];
   assign dac_ref_avdd_select        = s.cfg[CFG_REFSEL];
   assign bias_output_six_bit_select = s.cfg[CFG_VBMUX];
   assign zero_output_twelve_bit_select = s.cfg[CFG_VZMUX];
   assign waveform_source_select     = s.cfg[CFG_WAVE];

   logic wr_data_full;
   logic wr_ref_lo;
   logic wr_cm_lo;
   assign wr_data_full = rif.wr_req && rif.wr_addr[ADDR_W-1:2] == DATA_OFF[ADDR_W-1:2] &&
                         rif.wr_strb[2:0] == 3'h7;
   assign wr_ref_lo    = rif.wr_req && rif.wr_strb[0] &&
                         rif.wr_addr[ADDR_W-1:2] == REF_CTRL_OFF[ADDR_W-1:2];
   assign wr_cm_lo     = rif.wr_req && rif.wr_strb[0] &&
                         rif.wr_addr[ADDR_W-1:2] == CMODE_OFF[ADDR_W-1:2];

   AST_DIAG_ROUTING: assert property (
      @(posedge aclk) disable iff (!aresetn)
      (!s.cfg[CFG_PWD] && !s.sw[SW_OVERRIDE] && s.cfg[CFG_DIAG]) |=>
         {bias_to_pstat_input_switch, bias_to_filter_pin_switch,
          zero_to_lptia_input_switch, zero_to_filter_pin_switch,
          zero_to_hstia_input_switch} == SW_DIAG)
      else $error("diagnostic routing not applied");

   AST_NORMAL_ROUTING: assert property (
      @(posedge aclk) disable iff (!aresetn)
      (!s.cfg[CFG_PWD] && !s.sw[SW_OVERRIDE] && !s.cfg[CFG_DIAG]) |=>
         s.sw_out == SW_NORMAL)
      else $error("normal routing not applied");

   AST_OVERRIDE_ROUTING: assert property (
      @(posedge aclk) disable iff (!aresetn)
      (!s.cfg[CFG_PWD] && s.sw[SW_OVERRIDE]) |=> s.sw_out == $past(s.sw[4:0]))
      else $error("override switch bits not applied");

   AST_PSTAT_SWITCH: assert property (
      @(posedge aclk) disable iff (!aresetn)
      (!s.cfg[CFG_PWD] && s.sw[SW_OVERRIDE] && $stable(s.sw) && $stable(s.cfg)) |=>
         bias_to_pstat_input_switch == $past(s.sw[SW_BIAS_PSTAT]))
      else $error("bias to potentiostat switch mismatch");

   AST_BIAS_FILTER_SWITCH: assert property (
      @(posedge aclk) disable iff (!aresetn)
      (!s.cfg[CFG_PWD] && s.sw[SW_OVERRIDE]) ##1 $stable(s.sw) |->
         bias_to_filter_pin_switch == s.sw[SW_BIAS_FILTER])
      else $error("bias to filter switch mismatch");

   AST_LPTIA_SWITCH: assert property (
      @(posedge aclk) disable iff (!aresetn)
      $rose(s.sw[SW_ZERO_LPTIA]) && s.sw[SW_OVERRIDE] && !s.cfg[CFG_PWD] &&
         $stable(s.sw[SW_OVERRIDE]) && $stable(s.cfg) |=> zero_to_lptia_input_switch)
      else $error("zero to low power TIA switch did not close");

   AST_ZERO_FILTER_SWITCH: assert property (
      @(posedge aclk) disable iff (!aresetn)
      $fell(s.sw[SW_ZERO_FILTER]) && s.sw[SW_OVERRIDE] && !s.cfg[CFG_PWD] &&
         $stable(s.sw[SW_OVERRIDE]) && $stable(s.cfg) |=> !zero_to_filter_pin_switch)
      else $error("zero to filter switch did not open");

   AST_HSTIA_SWITCH: assert property (
      @(posedge aclk) disable iff (!aresetn)
      (!s.cfg[CFG_PWD] && s.sw[SW_OVERRIDE]) |=>
         zero_to_hstia_input_switch == $past(s.sw[SW_ZERO_HSTIA]))
      else $error("zero to high speed TIA switch mismatch");

   AST_SIX_BIT_CODE: assert property (
      @(posedge aclk) disable iff (!aresetn)
      (wr_data_full && s.cfg[CFG_WR_EN] && !next_s.cfg[CFG_WR_EN] == 1'b0) |=>
         six_bit_code == $past(rif.wr_data[CODE6_LSB +: CODE6_W]))
      else $error("six bit code not stored");

   AST_TWELVE_BIT_CODE: assert property (
      @(posedge aclk) disable iff (!aresetn)
      (wr_data_full && s.cfg[CFG_WR_EN]) |=>
         twelve_bit_code == $past(rif.wr_data[CODE12_LSB +: CODE12_W]))
      else $error("twelve bit code not stored");

   AST_BUFFER_POWERDOWN: assert property (
      @(posedge aclk) disable iff (!aresetn)
      wr_ref_lo |=> ref_buffer_powerdown == $past(rif.wr_data[REF_BUFFER_PD]))
      else $error("reference buffer power-down not stored");

   AST_BANDGAP_POWERDOWN: assert property (
      @(posedge aclk) disable iff (!aresetn)
      wr_ref_lo |=> bandgap_powerdown == $past(rif.wr_data[REF_BANDGAP_PD]))
      else $error("bandgap power-down not stored");

   AST_CM_SELECT: assert property (
      @(posedge aclk) disable iff (!aresetn)
      wr_cm_lo && !rif.wr_data[CM_SELECT] |=> !cm_switch_analog_input_a ##1
         (!cm_switch_analog_input_a || $changed(s.cm)))
      else $error("common-mode switches not off");

   AST_CM_BOTH_INPUTS: assert property (
      @(posedge aclk) disable iff (!aresetn)
      wr_cm_lo |=> cm_switch_analog_input_a == $past(rif.wr_data[CM_SELECT]) &&
         cm_switch_analog_input_b == cm_switch_analog_input_a)
      else $error("common-mode switches not driven on both inputs");

   AST_DATA_LOCKED: assert property (
      @(posedge aclk) disable iff (!aresetn)
      !s.cfg[CFG_WR_EN] |-> s.code6 == CODE6_RESET && s.code12 == CODE12_RESET &&
         reg_word(DATA_OFF, s) == 32'h0000_0000)
      else $error("data register not zero while writes disabled");

   AST_RESERVED_ZERO: assert property (
      @(posedge aclk) disable iff (!aresetn)
      rif.rd_req |-> rif.rd_data[31:CODE6_LSB+CODE6_W] == '0 &&
         (rif.rd_addr[ADDR_W-1:2] != SWITCH_OFF[ADDR_W-1:2] ||
          rif.rd_data[31:SW_W] == '0))
      else $error("reserved bits read non-zero");

   AST_POWERDOWN_OPENS: assert property (
      @(posedge aclk) disable iff (!aresetn)
      s.cfg[CFG_PWD] |=> s.sw_out == 5'h00)
      else $error("switches not open in power-down");

endmodule // ldr_regs
`default_nettype wire

// file: sim/ldr_regs_bench.sv
// Self-checking bench for the DAC switch and reference register bank
`timescale 1ns/1ns
`default_nettype none
module ldr_regs_bench;
   import ldr_pkg::*;
   logic              aclk = 1'b0;
   logic              aresetn = 1'b0;
   logic [ADDR_W-1:0] awaddr = '0;
   logic [ADDR_W-1:0] araddr = '0;
   logic [DATA_W-1:0] wdata = '0;
   logic [3:0]        wstrb = 4'hF;
   logic              awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
   logic              arvalid = 1'b0, rready = 1'b0;
   wire logic         awready, wready, bvalid, arready, rvalid;
   wire logic [1:0]   bresp, rresp, cm;
   wire logic [31:0]  rdata;
   wire logic [4:0]   sw, cfgo;
   wire logic [5:0]   c6;
   wire logic [11:0]  c12;
   wire logic         buf_pd, bg_pd;
   logic [31:0]       m [logic [15:0]];
   int                n_fail = 0;
   int                cmp_count = 0;
   logic [31:0]       rv;

   always #50 aclk = ~aclk;

   ldr_regs uut (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid),
      .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
      .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
      .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
      .bias_to_pstat_input_switch(sw[4]), .bias_to_filter_pin_switch(sw[3]),
      .zero_to_lptia_input_switch(sw[2]), .zero_to_filter_pin_switch(sw[1]),
      .zero_to_hstia_input_switch(sw[0]), .six_bit_code(c6), .twelve_bit_code(c12),
      .ref_buffer_powerdown(buf_pd), .bandgap_powerdown(bg_pd),
      .cm_switch_analog_input_a(cm[1]), .cm_switch_analog_input_b(cm[0]),
      .dac_powerdown(cfgo[0]), .dac_ref_avdd_select(cfgo[1]),
      .bias_output_six_bit_select(cfgo[2]), .zero_output_twelve_bit_select(cfgo[3]),
      .waveform_source_select(cfgo[4]));

   task automatic results;
      $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
      if (n_fail == 0 && cmp_count > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask

   task automatic cmp(input logic [31:0] got, input logic [31:0] exp, input string what);
      cmp_count++;
      if (got !== exp) begin
         n_fail++;
         $display("MISMATCH %0t %s got %h expected %h", $time, what, got, exp);
      end
   endtask

   // Behavioural register model: masks reserved bits and gates data writes
   function automatic void mdl_w(input logic [15:0] a, input logic [31:0] d);
      case (a)
         REF_CTRL_OFF: m[a] = d & 32'h0000_0003;
         DATA_OFF:     if (m[CONFIG_OFF][CFG_WR_EN]) m[a] = d & 32'h0003_FFFF;
         SWITCH_OFF:   m[a] = d & 32'h0000_003F;
         CONFIG_OFF: begin
            m[a] = d & 32'h0000_007F;
            if (!d[CFG_WR_EN]) m[DATA_OFF] = 32'h0000_0000;
         end
         CMODE_OFF:    m[a] = d & 32'h0000_0008;
         default: ;
      endcase
   endfunction

   task automatic chk_out;
      logic [31:0] c, s;
      logic [4:0]  e;
      c = m[CONFIG_OFF];
      s = m[SWITCH_OFF];
      e = c[CFG_PWD] ? 5'h00 : s[SW_OVERRIDE] ? s[4:0] : c[CFG_DIAG] ? SW_DIAG : SW_NORMAL;
      cmp({27'h0, sw}, {27'h0, e}, "switch outputs");
      cmp({14'h0, c6, c12}, m[DATA_OFF], "code outputs");
      cmp({30'h0, buf_pd, bg_pd}, m[REF_CTRL_OFF], "reference outputs");
      cmp({30'h0, cm}, {30'h0, {2{m[CMODE_OFF][CM_SELECT]}}}, "cm outputs");
      cmp({27'h0, cfgo}, {27'h0, c[6], c[4], c[3], c[2], c[1]}, "config outputs");
   endtask

   // Master keeps each channel up until its own handshake edge
   task automatic wr(input logic [15:0] a, input logic [31:0] d);
      int  t;
      bit  pa, pw, pb, ha, hw, hb;
      logic [1:0] r;
      @(posedge aclk);
      awaddr  <= a;
      wdata   <= d;
      awvalid <= 1'b1;
      wvalid  <= 1'b1;
      bready  <= 1'b1;
      pa = 1;
      pw = 1;
      pb = 1;
      t  = 0;
      r  = 2'h1;
      while (pa || pw || pb) begin
         @(negedge aclk);
         ha = pa && awready === 1'b1;
         hw = pw && wready === 1'b1;
         hb = pb && bvalid === 1'b1;
         if (hb) r = bresp;
         @(posedge aclk);
         if (ha) begin
            awvalid <= 1'b0;
            pa = 0;
         end
         if (hw) begin
            wvalid <= 1'b0;
            pw = 0;
         end
         if (hb) begin
            bready <= 1'b0;
            pb = 0;
         end
         if (++t > 50) begin
            n_fail++;
            results();
         end
      end
      cmp({30'h0, r}, {30'h0, m.exists(a) ? RESP_OKAY : RESP_SLVERR}, "write response");
      mdl_w(a, d);
      repeat (3) @(posedge aclk);
      chk_out();
   endtask

   task automatic rd(input logic [15:0] a);
      int  t;
      bit  pa, hr;
      logic [1:0] r;
      @(posedge aclk);
      araddr  <= a;
      arvalid <= 1'b1;
      rready  <= 1'b1;
      pa = 1;
      hr = 0;
      t  = 0;
      r  = 2'h1;
      rv = '0;
      while (!hr) begin
         @(negedge aclk);
         if (!pa && rvalid === 1'b1) begin
            hr = 1;
            r  = rresp;
            rv = rdata;
         end
         if (pa && arready === 1'b1) pa = 0;
         @(posedge aclk);
         if (!pa) arvalid <= 1'b0;
         if (hr) rready <= 1'b0;
         if (++t > 50) begin
            n_fail++;
            results();
         end
      end
      cmp(rv, m.exists(a) ? m[a] : 32'h0000_0000, "read data");
      cmp({30'h0, r}, {30'h0, m.exists(a) ? RESP_OKAY : RESP_SLVERR}, "read response");
   endtask

   initial begin
      repeat (20000) @(posedge aclk);
      n_fail++;
      results();
   end

   initial begin
      logic [15:0] regs [5];
      regs = '{REF_CTRL_OFF, DATA_OFF, SWITCH_OFF, CONFIG_OFF, CMODE_OFF};
      foreach (regs[i]) m[regs[i]] = 32'h0000_0000;
      m[CONFIG_OFF] = {25'h0, CFG_RESET};
      rv = $urandom(32'hf08e);
      repeat (3) @(posedge aclk);
      aresetn <= 1'b1;
      foreach (regs[i]) rd(regs[i]);
      chk_out();
      wr(DATA_OFF, $urandom());
      rd(DATA_OFF);
      wr(CONFIG_OFF, 32'hFFFF_FF81);
      rd(CONFIG_OFF);
      for (int i = 0; i < 5; i++) begin
         wr(DATA_OFF, i == 0 ? 32'hFFFF_FFFF : $urandom());
         rd(DATA_OFF);
      end
      wr(SWITCH_OFF, 32'hFFFF_FFC0);
      wr(CONFIG_OFF, 32'h0000_0021);
      for (int i = 0; i < 5; i++) begin
         wr(SWITCH_OFF, 32'h0000_0020 | (32'h0000_0001 << i));
         rd(SWITCH_OFF);
      end
      repeat (4) wr(SWITCH_OFF, $urandom() | 32'h0000_0020);
      wr(CONFIG_OFF, 32'h0000_0023);
      for (int i = 0; i < 4; i++) begin
         wr(REF_CTRL_OFF, ($urandom() & 32'hFFFF_FFFC) | i);
         rd(REF_CTRL_OFF);
      end
      wr(CMODE_OFF, 32'hFFFF_FFFF);
      rd(CMODE_OFF);
      wr(CMODE_OFF, 32'h0000_0007);
      rd(CMODE_OFF);
      wr(CONFIG_OFF, 32'h0000_0000);
      rd(DATA_OFF);
      wr(16'h2000, $urandom());
      rd(16'h2000);
      results();
   end
endmodule // ldr_regs_bench
`default_nettype wire
